// File: hw/rcp_consts.svh
`ifndef RCP_CONSTS_SVH
`define RCP_CONSTS_SVH

// Clock period in nanoseconds (250 MHz core clock).
`define RCP_CLK_PERIOD_NS      32'h0000_0004
// Debounce settle time in microseconds (5000).
`define RCP_DEBOUNCE_US        32'h0000_1388
// Settle time as a cycle count; working in nanoseconds keeps the product inside 32 bits.
`define RCP_DEBOUNCE_CYCLES    ((`RCP_DEBOUNCE_US * 32'h0000_03E8) / `RCP_CLK_PERIOD_NS)
// Alarm pulse time after a locked-out start press, in microseconds (100000).
`define RCP_ALARM_US           32'h0001_86A0
`define RCP_ALARM_CYCLES       ((`RCP_ALARM_US * 32'h0000_03E8) / `RCP_CLK_PERIOD_NS)
`define RCP_CNT_W              32
`define RCP_CNT_ONE            32'h0000_0001
`define RCP_CNT_ZERO           32'h0000_0000
`define RCP_PROG_NONE          2'h0
`define RCP_PROG_ONE           2'h1
`define RCP_PROG_TWO           2'h2
`define RCP_PROG_THREE         2'h3

`endif

// File: hw/rcp_pkg.sv
package rcp_pkg;
   typedef logic [1:0] rcp_prog_t;

   typedef enum logic [2:0] {
      RCP_IDLE = 3'h1,
      RCP_RUN  = 3'h2,
      RCP_ERR  = 3'h4
   } rcp_state_e;
endpackage

// File: hw/rcp_filt_if.sv
`timescale 1ns/1ps
interface rcp_filt_if;
   logic raw;
   logic clean;
   logic rise;
   logic fall;

   modport filt (
      input  raw,
      output clean,
      output rise,
      output fall
   );
   modport user (
      output raw,
      input  clean,
      input  rise,
      input  fall
   );
endinterface

// File: hw/rcp_debounce.sv
`timescale 1ns/1ps
`include "rcp_consts.svh"
module rcp_debounce #(
   parameter logic [`RCP_CNT_W-1:0] SETTLE = `RCP_DEBOUNCE_CYCLES
) (
   input  wire logic  core_clk,
   input  wire logic  nrst,
   rcp_filt_if.filt   f
);
   logic                  s1_q, s1_d;
   logic                  s2_q, s2_d;
   logic                  cl_q, cl_d;
   logic                  rise_q, rise_d;
   logic                  fall_q, fall_d;
   logic [`RCP_CNT_W-1:0] cnt_q, cnt_d;

   always_comb begin
      s1_d   = f.raw;
      s2_d   = s1_q;
      cl_d   = cl_q;
      rise_d = 1'b0;
      fall_d = 1'b0;
      cnt_d  = `RCP_CNT_ZERO;
      // Only the second stage is looked at; the first may be metastable.
      if (s2_q != cl_q) begin // RULE9
         if (cnt_q >= SETTLE - `RCP_CNT_ONE) begin
            cl_d   = s2_q;
            rise_d = s2_q;
            fall_d = ~s2_q;
         end else begin
            cnt_d = cnt_q + `RCP_CNT_ONE;
         end
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         s1_q   <= 1'b0;
         s2_q   <= 1'b0;
         cl_q   <= 1'b0;
         rise_q <= 1'b0;
         fall_q <= 1'b0;
         cnt_q  <= `RCP_CNT_ZERO;
      end else begin
         s1_q   <= s1_d;
         s2_q   <= s2_d;
         cl_q   <= cl_d;
         rise_q <= rise_d;
         fall_q <= fall_d;
         cnt_q  <= cnt_d;
      end
   end

   assign f.clean = cl_q;
   assign f.rise  = rise_q;
   assign f.fall  = fall_q;
endmodule

// File: hw/rcp_remote_ctrl.sv
// Summary of operation
// RULE1: Contact inputs act only when mode enabled.
// RULE2: Remote mode blocks front-panel start button.
// RULE3: Locked press shows message, alarms, keeps state.
// RULE4: Contacts start and stop one of three programs.
// RULE5: First select line alone picks program one.
// RULE6: Second select line alone picks program two; code keeps program three when only it stays closed after both were closed.
// RULE7: Both select lines together pick program three; code picks program one when the second line opens before the first.
// RULE8: In error, reset button or contact resets.
// RULE9: Inputs synchronised, debounced, selects sampled together.
`timescale 1ns/1ps
`include "rcp_consts.svh"
module rcp_remote_ctrl #(
   parameter logic [`RCP_CNT_W-1:0] DEBOUNCE_CYCLES = `RCP_DEBOUNCE_CYCLES,
   parameter logic [`RCP_CNT_W-1:0] ALARM_CYCLES    = `RCP_ALARM_CYCLES
) (
   input  wire logic        core_clk,
   input  wire logic        nrst,
   input  wire logic        remote_mode_en,
   input  wire logic        onoff_contact,
   input  wire logic        sel_one_contact,
   input  wire logic        sel_two_contact,
   input  wire logic        panel_start_btn,
   input  wire logic        panel_reset_btn,
   input  wire logic        panel_stop_btn,
   input  wire logic        error_flag,
   input  wire logic        panel_run_req,
   output logic             prog_run,
   output logic [1:0]       prog_select,
   output logic             stored_program_one,
   output logic             stored_program_two,
   output logic             stored_program_three,
   output logic             remote_lock_message,
   output logic             alarm,
   output logic             system_reset
);
   rcp_filt_if onoff_f ();
   rcp_filt_if sel1_f ();
   rcp_filt_if sel2_f ();

   assign onoff_f.raw = onoff_contact;
   assign sel1_f.raw  = sel_one_contact;
   assign sel2_f.raw  = sel_two_contact;

   rcp_debounce #(.SETTLE(DEBOUNCE_CYCLES)) u_onoff (
      .core_clk (core_clk),
      .nrst     (nrst),
      .f        (onoff_f.filt)
   );
   rcp_debounce #(.SETTLE(DEBOUNCE_CYCLES)) u_sel1 (
      .core_clk (core_clk),
      .nrst     (nrst),
      .f        (sel1_f.filt)
   );
   rcp_debounce #(.SETTLE(DEBOUNCE_CYCLES)) u_sel2 (
      .core_clk (core_clk),
      .nrst     (nrst),
      .f        (sel2_f.filt)
   );

   rcp_pkg::rcp_state_e   st_q, st_d;
   rcp_pkg::rcp_prog_t    prog_q, prog_d;
   rcp_pkg::rcp_prog_t    pend_q, pend_d;
   logic                  start_prev_q, start_prev_d;
   logic [`RCP_CNT_W-1:0] alm_q, alm_d;
   logic                  lock_q, lock_d;
   logic                  alarm_q, alarm_d;
   logic                  rst_q, rst_d;
   logic                  p1_q, p1_d;
   logic                  p2_q, p2_d;
   logic                  p3_q, p3_d;
   logic                  run_q, run_d;
   logic                  start_press;
   logic                  any_sel;

   assign start_press = panel_start_btn & ~start_prev_q;
   assign any_sel     = sel1_f.clean | sel2_f.clean;

   always_comb begin
      st_d         = st_q;
      prog_d       = prog_q;
      pend_d       = pend_q;
      start_prev_d = panel_start_btn;
      alm_d        = alm_q;
      lock_d       = lock_q;
      alarm_d      = alarm_q;
      rst_d        = 1'b0;

      // Program three is held while only the second line stays closed, so a
      // closure whose halves open apart still reads as one unless the second opens first.
      if (remote_mode_en && any_sel) begin // RULE9
         pend_d = {sel2_f.clean, sel1_f.clean}; // RULE7
         if (sel1_f.clean && !sel2_f.clean) begin
            pend_d = `RCP_PROG_ONE; // RULE5
         end else if (sel2_f.clean && !sel1_f.clean && pend_q != `RCP_PROG_THREE) begin
            pend_d = `RCP_PROG_TWO; // RULE6
         end else if (sel1_f.clean && sel2_f.clean) begin
            pend_d = `RCP_PROG_THREE; // RULE7
         end else begin
            pend_d = pend_q;
         end
      end else if (remote_mode_en && pend_q != `RCP_PROG_NONE && st_q != rcp_pkg::RCP_RUN) begin
         prog_d = pend_q; // RULE4
         pend_d = `RCP_PROG_NONE;
      end else begin
         pend_d = `RCP_PROG_NONE;
      end

      case (st_q)
         rcp_pkg::RCP_IDLE: begin
            if (error_flag) begin
               st_d = rcp_pkg::RCP_ERR;
            end else if (remote_mode_en) begin // RULE1
               if (onoff_f.rise && prog_q != `RCP_PROG_NONE) begin
                  st_d = rcp_pkg::RCP_RUN; // RULE4
               end
            end else if (panel_run_req) begin
               st_d = rcp_pkg::RCP_RUN;
            end
         end
         rcp_pkg::RCP_RUN: begin
            if (error_flag) begin
               st_d = rcp_pkg::RCP_ERR;
            end else if (remote_mode_en && onoff_f.fall) begin // RULE1
               st_d = rcp_pkg::RCP_IDLE; // RULE4
            end else if (panel_stop_btn) begin
               st_d = rcp_pkg::RCP_IDLE;
            end
         end
         rcp_pkg::RCP_ERR: begin
            if (panel_reset_btn ||
                (remote_mode_en && (onoff_f.rise || onoff_f.fall))) begin
               rst_d = 1'b1; // RULE8
               st_d  = rcp_pkg::RCP_IDLE;
            end
         end
         default: st_d = rcp_pkg::RCP_IDLE;
      endcase

      // The lockout leaves the run state untouched so the unit returns to
      // where it was once the message times out.
      if (remote_mode_en && start_press) begin // RULE2
         lock_d  = 1'b1; // RULE3
         alarm_d = 1'b1; // RULE3
         alm_d   = ALARM_CYCLES;
      end else if (alm_q != `RCP_CNT_ZERO) begin
         alm_d = alm_q - `RCP_CNT_ONE;
      end else begin
         lock_d  = 1'b0; // RULE3
         alarm_d = 1'b0;
      end

      p1_d = (prog_d == `RCP_PROG_ONE);
      p2_d = (prog_d == `RCP_PROG_TWO);
      p3_d = (prog_d == `RCP_PROG_THREE);
      run_d = (st_d == rcp_pkg::RCP_RUN);
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         st_q         <= rcp_pkg::RCP_IDLE;
         prog_q       <= `RCP_PROG_NONE;
         pend_q       <= `RCP_PROG_NONE;
         start_prev_q <= 1'b0;
         alm_q        <= `RCP_CNT_ZERO;
         lock_q       <= 1'b0;
         alarm_q      <= 1'b0;
         rst_q        <= 1'b0;
         p1_q         <= 1'b0;
         p2_q         <= 1'b0;
         p3_q         <= 1'b0;
         run_q        <= 1'b0;
      end else begin
         st_q         <= st_d;
         prog_q       <= prog_d;
         pend_q       <= pend_d;
         start_prev_q <= start_prev_d;
         alm_q        <= alm_d;
         lock_q       <= lock_d;
         alarm_q      <= alarm_d;
         rst_q        <= rst_d;
         p1_q         <= p1_d;
         p2_q         <= p2_d;
         p3_q         <= p3_d;
         run_q        <= run_d;
      end
   end

   assign prog_run             = run_q;
   assign prog_select          = prog_q;
   assign stored_program_one   = p1_q;
   assign stored_program_two   = p2_q;
   assign stored_program_three = p3_q;
   assign remote_lock_message  = lock_q;
   assign alarm                = alarm_q;
   assign system_reset         = rst_q;
endmodule

// File: sim/rcp_remote_ctrl_props.sv
`timescale 1ns/1ps
module rcp_remote_ctrl_props #(
   parameter logic [31:0] DEBOUNCE_CYCLES = 32'h0000_0004,
   parameter logic [31:0] ALARM_CYCLES    = 32'h0000_0008
) (
   input wire logic       core_clk,
   input wire logic       nrst,
   input wire logic       remote_mode_en,
   input wire logic       onoff_contact,
   input wire logic       sel_one_contact,
   input wire logic       sel_two_contact,
   input wire logic       panel_start_btn,
   input wire logic       panel_reset_btn,
   input wire logic       panel_stop_btn,
   input wire logic       error_flag,
   input wire logic       panel_run_req,
   input wire logic       prog_run,
   input wire logic [1:0] prog_select,
   input wire logic       stored_program_one,
   input wire logic       stored_program_two,
   input wire logic       stored_program_three,
   input wire logic       remote_lock_message,
   input wire logic       alarm,
   input wire logic       system_reset
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);
   property p_one; stored_program_one == (prog_select == 2'h1); endproperty
   a_one: assert property (p_one) else $error("program one flag wrong");
   property p_two; stored_program_two == (prog_select == 2'h2); endproperty
   a_two: assert property (p_two) else $error("program two flag wrong");
   property p_three; stored_program_three == (prog_select == 2'h3); endproperty
   a_three: assert property (p_three) else $error("program three flag wrong");
   property p_lock;
      $rose(panel_start_btn) && remote_mode_en |=> remote_lock_message && alarm;
   endproperty
   a_lock: assert property (p_lock) else $error("no lock message");
   property p_keep;
      $rose(panel_start_btn) && remote_mode_en |=> prog_run == $past(prog_run);
   endproperty
   a_keep: assert property (p_keep) else $error("start button acted");
   // Counting the high cycles keeps the check valid for any alarm length.
   logic [31:0] alm_len_q;
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         alm_len_q <= 32'h0000_0000;
      end else if (alarm) begin
         alm_len_q <= alm_len_q + 32'h0000_0001;
      end else begin
         alm_len_q <= 32'h0000_0000;
      end
   end
   property p_alarm; $fell(alarm) |-> alm_len_q == ALARM_CYCLES + 32'h0000_0001; endproperty
   a_alarm: assert property (p_alarm) else $error("alarm length wrong");
   property p_start; $rose(prog_run) && remote_mode_en |-> prog_select != 2'h0; endproperty
   a_start: assert property (p_start) else $error("run without program");
   property p_mode_off;
      !remote_mode_en && !prog_run && $rose(onoff_contact) |=> !prog_run[*8];
   endproperty
   a_mode_off: assert property (p_mode_off) else $error("contact acted when off");
   property p_debounce;
      remote_mode_en && !prog_run && $rose(onoff_contact) |=> !prog_run[*4];
   endproperty
   a_debounce: assert property (p_debounce) else $error("contact not filtered");
   property p_err_rst;
      $rose(panel_reset_btn) && $past(error_flag) |-> ##[1:2] system_reset;
   endproperty
   a_err_rst: assert property (p_err_rst) else $error("no system reset");
   property p_pulse; system_reset |=> !system_reset && !prog_run; endproperty
   a_pulse: assert property (p_pulse) else $error("reset pulse wrong");
   c_alarm: cover property ($rose(alarm));
   c_reset: cover property (system_reset);
   c_run3: cover property (prog_run && prog_select == 2'h3);
endmodule
bind rcp_remote_ctrl rcp_remote_ctrl_props #(
   .DEBOUNCE_CYCLES (DEBOUNCE_CYCLES),
   .ALARM_CYCLES    (ALARM_CYCLES)
) u_props (
   .core_clk             (core_clk),
   .nrst                 (nrst),
   .remote_mode_en       (remote_mode_en),
   .onoff_contact        (onoff_contact),
   .sel_one_contact      (sel_one_contact),
   .sel_two_contact      (sel_two_contact),
   .panel_start_btn      (panel_start_btn),
   .panel_reset_btn      (panel_reset_btn),
   .panel_stop_btn       (panel_stop_btn),
   .error_flag           (error_flag),
   .panel_run_req        (panel_run_req),
   .prog_run             (prog_run),
   .prog_select          (prog_select),
   .stored_program_one   (stored_program_one),
   .stored_program_two   (stored_program_two),
   .stored_program_three (stored_program_three),
   .remote_lock_message  (remote_lock_message),
   .alarm                (alarm),
   .system_reset         (system_reset)
);

// File: sim/rcp_switch_box.sv
`timescale 1ns/1ps
module rcp_switch_box (
   input  wire logic [1:0] sel_req,
   input  wire logic       on_req,
   output logic            onoff_contact,
   output logic            sel_one_contact,
   output logic            sel_two_contact
);
   // An open dry contact reads low through the device's pull-down.
   assign onoff_contact   = on_req;
   // The third program closes both lines at once through the steering diodes.
   assign sel_one_contact = sel_req[0];
   assign sel_two_contact = sel_req[1];
endmodule

// File: sim/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic       core_clk;
   logic       nrst;
   logic       remote_mode_en;
   logic [1:0] sel_req;
   logic       on_req;
   logic       panel_start_btn;
   logic       panel_reset_btn;
   logic       error_flag;
   logic       panel_stop_btn;
   logic       panel_run_req;
   logic       onoff_c;
   logic       sel1_c;
   logic       sel2_c;
   logic       prog_run;
   logic [1:0] prog_select;
   logic       p_one;
   logic       p_two;
   logic       p_three;
   logic       lock_msg;
   logic       alarm;
   logic       system_reset;
   int         err_total;
   int         check_count;
   int         rst_pulses;
   rcp_switch_box box (.sel_req(sel_req), .on_req(on_req), .onoff_contact(onoff_c),
      .sel_one_contact(sel1_c), .sel_two_contact(sel2_c));
   rcp_remote_ctrl #(.DEBOUNCE_CYCLES(32'h0000_0004), .ALARM_CYCLES(32'h0000_0008)) dut (
      .core_clk(core_clk), .nrst(nrst), .remote_mode_en(remote_mode_en),
      .onoff_contact(onoff_c), .sel_one_contact(sel1_c), .sel_two_contact(sel2_c),
      .panel_start_btn(panel_start_btn), .panel_reset_btn(panel_reset_btn),
      .panel_stop_btn(panel_stop_btn), .error_flag(error_flag),
      .panel_run_req(panel_run_req),
      .prog_run(prog_run), .prog_select(prog_select), .stored_program_one(p_one),
      .stored_program_two(p_two), .stored_program_three(p_three),
      .remote_lock_message(lock_msg), .alarm(alarm), .system_reset(system_reset));
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   always @(posedge core_clk) if (system_reset === 1'b1) rst_pulses <= rst_pulses + 1;
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic chk(input logic [2:0] got, input logic [2:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic t_sel(input logic [1:0] s);
      @(posedge core_clk) sel_req <= s;
      cyc(12);
      @(posedge core_clk) sel_req <= 2'h0;
      cyc(12);
      chk({1'b0, prog_select}, {1'b0, s});
      chk({p_three, p_two, p_one}, 3'h1 << (s - 2'h1));
   endtask
   task automatic t_on(input logic v);
      @(posedge core_clk) on_req <= v;
      cyc(12);
      chk({2'h0, prog_run}, {2'h0, v});
   endtask
   task automatic t_lock;
      @(posedge core_clk) panel_start_btn <= 1'b1;
      cyc(2);
      chk({prog_run, lock_msg, alarm}, 3'h7);
      @(posedge core_clk) panel_start_btn <= 1'b0;
      cyc(12);
      chk({prog_run, lock_msg, alarm}, 3'h4);
   endtask
   task automatic t_panel;
      @(posedge core_clk) {panel_start_btn, panel_run_req} <= 2'h3;
      cyc(2);
      chk({prog_run, lock_msg, alarm}, 3'h3);
      @(posedge core_clk) {panel_start_btn, panel_run_req} <= 2'h0;
      remote_mode_en <= 1'b0;
      cyc(12);
      @(posedge core_clk) panel_run_req <= 1'b1;
      @(posedge core_clk) panel_run_req <= 1'b0;
      cyc(2);
      chk({prog_run, lock_msg, alarm}, 3'h4);
      @(posedge core_clk) panel_stop_btn <= 1'b1;
      @(posedge core_clk) panel_stop_btn <= 1'b0;
      cyc(2);
      chk({prog_run, lock_msg, alarm}, 3'h0);
   endtask
   task automatic t_mode_off;
      @(posedge core_clk) remote_mode_en <= 1'b0;
      sel_req <= 2'h2;
      cyc(12);
      @(posedge core_clk) sel_req <= 2'h0;
      on_req <= 1'b1;
      cyc(12);
      chk({prog_run, prog_select}, 3'h3);
      @(posedge core_clk) on_req <= 1'b0;
      cyc(12);
      @(posedge core_clk) remote_mode_en <= 1'b1;
   endtask
   task automatic t_err;
      @(posedge core_clk) error_flag <= 1'b1;
      @(posedge core_clk) error_flag <= 1'b0;
      panel_reset_btn <= 1'b1;
      @(posedge core_clk) panel_reset_btn <= 1'b0;
      cyc(4);
      chk({prog_run, rst_pulses[1:0]}, 3'h1);
      // A second error is cleared by closing the remote on/off contact.
      @(posedge core_clk) error_flag <= 1'b1;
      @(posedge core_clk) error_flag <= 1'b0;
      on_req <= 1'b1;
      cyc(12);
      chk({prog_run, rst_pulses[1:0]}, 3'h2);
   endtask
   task automatic conclude;
      if (err_total == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      repeat (2000) @(posedge core_clk);
      err_total++;
      conclude();
   end
   initial begin
      {nrst, remote_mode_en, sel_req, on_req} = 5'h08;
      {panel_start_btn, panel_reset_btn, error_flag, panel_stop_btn, panel_run_req} = 5'h00;
      err_total = 0;
      check_count = 0;
      repeat (12) @(posedge core_clk);
      nrst <= 1'b1;
      cyc(2);
      t_sel(2'h1);
      t_sel(2'h2);
      t_sel(2'h3);
      t_on(1'b1);
      t_lock();
      t_on(1'b0);
      t_panel();
      t_mode_off();
      t_err();
      conclude();
   end
endmodule
